// ==== hdl/cpbid_map.vh ====
// Purpose: register map, field positions and reset values of the compander breakpoint bank
// Assumes: included by bare name from the pixel output and top design files
// Notes: register indices; byte address on the bus is four times the index
`ifndef CPBID_MAP_VH
`define CPBID_MAP_VH

// ****************************************************************
// register indices
// ****************************************************************
`define CPBID_IDX_W 7
`define CPBID_IDX_SEG2_LOW 7'h22
`define CPBID_IDX_SEG3_HIGH 7'h23
`define CPBID_IDX_SEG3_LOW 7'h24
`define CPBID_IDX_PART_ID 7'h25
`define CPBID_IDX_SIL_REV 7'h26
`define CPBID_IDX_CTRL 7'h30
`define CPBID_IDX_STATUS 7'h31

// ****************************************************************
// reset values
// ****************************************************************
`define CPBID_RST_SEG2_LOW 8'h18
`define CPBID_RST_SEG3_HIGH 8'h0b
`define CPBID_RST_SEG3_LOW 8'h58
`define CPBID_RST_CTRL 8'h00
`define CPBID_ZERO_BYTE 8'h00
`define CPBID_ZERO_WORD 32'h0000_0000

// ****************************************************************
// fields
// ****************************************************************
`define CPBID_HIGH_W 5
`define CPBID_HIGH_MASK 8'h1f
`define CPBID_CTRL_STROBE_SEL 0
`define CPBID_STAT_CLAMP 0
`define CPBID_STAT_SERIAL_BUSY 1
`define CPBID_STAT_SEG_LO 2
`define CPBID_STAT_SEG_HI 3
`define CPBID_STAT_PIXEL_OPEN 4
`define CPBID_SEG_FIRST 2'h0
`define CPBID_SEG_SECOND 2'h1
`define CPBID_SEG_THIRD 2'h2

// ****************************************************************
// serial frame
// ****************************************************************
`define CPBID_SER_CNT_W 5
`define CPBID_SER_ADDR_BITS 5'h08
`define CPBID_SER_FRAME_BITS 5'h10
`define CPBID_SER_READ_BIT 7
`define CPBID_BYTE_LANE_BITS 2
`define CPBID_BYTE_ALIGNED 2'h0

`endif

// ==== hdl/cpbid_sync.v ====
// Purpose: two-stage synchroniser for pins entering the system clock domain
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps

module cpbid_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_sync_n,
  input wire clk_en,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_ff
);

  reg [WIDTH-1:0] meta_ff;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule // cpbid_sync

// ==== hdl/cpbid_pixel_out.v ====
// Purpose: parallel pixel output stage with selectable clock or data-valid strobe
// Assumes: sample edges already synchronised and edge-detected
// Notes: all outputs come from flip-flops
`timescale 1ns/1ps
`include "cpbid_map.vh"

module cpbid_pixel_out #(
  parameter DATA_W = 13
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_sync_n,
  input wire clk_en,
  // timing
  input wire level_rise,
  input wire level_clk_level,
  input wire strobe_select,
  // data
  input wire [DATA_W-1:0] adc_sample,
  input wire [DATA_W-1:0] seg2_end,
  input wire [DATA_W-1:0] seg3_end,
  output reg [DATA_W-1:0] data_ff,
  output reg strobe_ff,
  output reg [1:0] segment_ff
);

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_ff <= {DATA_W{1'b0}};
      strobe_ff <= 1'b0;
      segment_ff <= `CPBID_SEG_FIRST;
    end else if (clk_en) begin
      if (level_rise) begin
        data_ff <= adc_sample;
        if (adc_sample <= seg2_end) begin
          segment_ff <= `CPBID_SEG_FIRST;
        end else if (adc_sample <= seg3_end) begin
          segment_ff <= `CPBID_SEG_SECOND;
        end else begin
          segment_ff <= `CPBID_SEG_THIRD;
        end
      end
      if (strobe_select) begin
        strobe_ff <= level_rise;
      end else begin
        strobe_ff <= level_clk_level;
      end
    end
  end

endmodule // cpbid_pixel_out

// ==== hdl/cpbid_top.v ====
// Purpose: compander breakpoint and identity registers, serial and bus access, pixel output
// Assumes: Avalon-MM slave with waitrequest; pins synchronised to clk_sys
// Notes: bus byte address is four times the register index; data in byte lane 0
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "cpbid_map.vh"

// How it works
// - byte 0x22 read/write, second segment end low bits, resets to 0x18
// - byte 0x23 read/write, bits 4:0 third segment high, upper reserved, 0x0B
// - byte 0x24 read/write, third segment end low bits, resets to 0x58
// - byte 0x25 read-only part identity code; writes ignored
// - byte 0x26 read-only silicon revision code; writes ignored
// - strobe pin carries pixel clock or data-valid pulse per control select
// - thirteen-bit parallel sample output, bit zero least significant
// - serial clock and data ignored while serial select is high
// - low reset input returns every register to default while held
module cpbid_top #(
  parameter DATA_W = 13,
  parameter [7:0] PART_IDENTITY = 8'h5a,   // arbitrary value
  parameter [7:0] SILICON_REVISION = 8'h01 // arbitrary value
) (
  // clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // avalon-mm slave
  input wire [8:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // serial pins
  input wire serial_clk,
  input wire serial_select_n,
  input wire serial_data_in,
  output reg serial_data_out,
  // timing generator pins
  input wire clamp_in,
  input wire feedthrough_sample_clk,
  input wire level_sample_clk,
  // converter side
  input wire [DATA_W-1:0] adc_sample,
  input wire [4:0] seg2_end_high_in,
  // outputs
  output wire [DATA_W-1:0] pixel_data_out,
  output wire pixel_strobe_out,
  output reg [DATA_W-1:0] seg2_end_value,
  output reg [DATA_W-1:0] seg3_end_value
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_sync_n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_sync_n = rst_sync_ff;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [5:0] pins_sync;
  wire sclk_s;
  wire sel_n_s;
  wire sdi_s;
  wire clamp_s;
  wire ft_s;
  wire lvl_s;

  cpbid_sync #(
    .WIDTH(6),
    .INIT(6'h02)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .async_in({level_sample_clk, feedthrough_sample_clk, clamp_in,
               serial_data_in, serial_select_n, serial_clk}),
    .sync_ff(pins_sync)
  );
  assign sclk_s = pins_sync[0];
  assign sel_n_s = pins_sync[1];
  assign sdi_s = pins_sync[2];
  assign clamp_s = pins_sync[3];
  assign ft_s = pins_sync[4];
  assign lvl_s = pins_sync[5];

  reg sclk_d_ff;
  reg ft_d_ff;
  reg lvl_d_ff;
  wire sclk_rise;
  wire sclk_fall;
  wire ft_rise;
  wire lvl_rise;

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign ft_rise = ft_s & ~ft_d_ff;
  assign lvl_rise = lvl_s & ~lvl_d_ff;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] seg2_end_low_bits_ff;
  reg [7:0] seg3_end_high_bits_ff;
  reg [7:0] seg3_end_low_bits_ff;
  reg [7:0] ctrl_ff;
  reg pixel_open_ff;
  wire [1:0] segment_code;

  function [DATA_W-1:0] join_end;
    input [4:0] high;
    input [7:0] low;
    begin
      join_end = {high, low};
    end
  endfunction

  function [7:0] read_reg;
    input [`CPBID_IDX_W-1:0] idx;
    begin
      case (idx)
        `CPBID_IDX_SEG2_LOW: read_reg = seg2_end_low_bits_ff;
        `CPBID_IDX_SEG3_HIGH: read_reg = seg3_end_high_bits_ff & `CPBID_HIGH_MASK;
        `CPBID_IDX_SEG3_LOW: read_reg = seg3_end_low_bits_ff;
        `CPBID_IDX_PART_ID: read_reg = PART_IDENTITY;
        `CPBID_IDX_SIL_REV: read_reg = SILICON_REVISION;
        `CPBID_IDX_CTRL: read_reg = ctrl_ff;
        `CPBID_IDX_STATUS: begin
          read_reg = `CPBID_ZERO_BYTE;
          read_reg[`CPBID_STAT_CLAMP] = clamp_s;
          read_reg[`CPBID_STAT_SERIAL_BUSY] = ~sel_n_s;
          read_reg[`CPBID_STAT_SEG_HI:`CPBID_STAT_SEG_LO] = segment_code;
          read_reg[`CPBID_STAT_PIXEL_OPEN] = pixel_open_ff;
        end
        default: read_reg = `CPBID_ZERO_BYTE;
      endcase
    end
  endfunction

  // ****************************************************************
  // avalon decode
  // ****************************************************************
  wire [`CPBID_IDX_W-1:0] bus_idx;
  wire bus_aligned;
  wire bus_req;
  wire bus_done;
  wire bus_wr;

  assign bus_idx = avs_address[8:`CPBID_BYTE_LANE_BITS];
  assign bus_aligned = (avs_address[`CPBID_BYTE_LANE_BITS-1:0] == `CPBID_BYTE_ALIGNED);
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~avs_waitrequest;
  assign bus_wr = bus_done & avs_write & avs_byteenable[0] & bus_aligned;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `CPBID_ZERO_WORD;
    end else if (clk_en) begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_read && bus_aligned) begin
          avs_readdata <= {24'h00_0000, read_reg(bus_idx)};
        end else begin
          avs_readdata <= `CPBID_ZERO_WORD;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // serial slave
  // ****************************************************************
  reg [`CPBID_SER_CNT_W-1:0] ser_cnt_ff;
  reg [7:0] ser_addr_ff;
  reg [7:0] ser_shift_ff;
  reg [7:0] ser_out_ff;
  wire ser_active;
  wire ser_is_read;
  wire ser_wr;

  assign ser_active = ~sel_n_s;
  assign ser_is_read = ser_addr_ff[`CPBID_SER_READ_BIT];
  assign ser_wr = ser_active & sclk_rise & ~ser_is_read &
                  (ser_cnt_ff == `CPBID_SER_FRAME_BITS - 5'h01);

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ser_cnt_ff <= {`CPBID_SER_CNT_W{1'b0}};
      ser_addr_ff <= `CPBID_ZERO_BYTE;
      ser_shift_ff <= `CPBID_ZERO_BYTE;
      ser_out_ff <= `CPBID_ZERO_BYTE;
      serial_data_out <= 1'b0;
    end else if (clk_en) begin
      if (!ser_active) begin
        ser_cnt_ff <= {`CPBID_SER_CNT_W{1'b0}};
      end else begin
        if (sclk_rise && ser_cnt_ff != `CPBID_SER_FRAME_BITS) begin
          ser_cnt_ff <= ser_cnt_ff + 5'h01;
          ser_shift_ff <= {ser_shift_ff[6:0], sdi_s};
          if (ser_cnt_ff == `CPBID_SER_ADDR_BITS - 5'h01) begin
            ser_addr_ff <= {ser_shift_ff[6:0], sdi_s};
            // snapshot the register named by the low seven address bits
            ser_out_ff <= read_reg({ser_shift_ff[5:0], sdi_s});
          end
        end
        if (sclk_fall && ser_is_read && ser_cnt_ff >= `CPBID_SER_ADDR_BITS) begin
          serial_data_out <= ser_out_ff[7];
          ser_out_ff <= {ser_out_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  reg wr_en;
  reg [`CPBID_IDX_W-1:0] wr_idx;
  reg [7:0] wr_data;

  // bus access wins over a serial write in the same cycle
  always @* begin
    wr_en = 1'b0;
    wr_idx = bus_idx;
    wr_data = avs_writedata[7:0];
    if (bus_wr) begin
      wr_en = 1'b1;
    end else if (ser_wr) begin
      wr_en = 1'b1;
      wr_idx = ser_addr_ff[`CPBID_IDX_W-1:0];
      wr_data = {ser_shift_ff[6:0], sdi_s};
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seg2_end_low_bits_ff <= `CPBID_RST_SEG2_LOW;
      seg3_end_high_bits_ff <= `CPBID_RST_SEG3_HIGH;
      seg3_end_low_bits_ff <= `CPBID_RST_SEG3_LOW;
      ctrl_ff <= `CPBID_RST_CTRL;
    end else if (clk_en && wr_en) begin
      case (wr_idx)
        `CPBID_IDX_SEG2_LOW: seg2_end_low_bits_ff <= wr_data;
        `CPBID_IDX_SEG3_HIGH: seg3_end_high_bits_ff <= wr_data & `CPBID_HIGH_MASK;
        `CPBID_IDX_SEG3_LOW: seg3_end_low_bits_ff <= wr_data;
        `CPBID_IDX_CTRL: ctrl_ff <= wr_data;
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // ****************************************************************
  // compander end values and pixel timing
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seg2_end_value <= {DATA_W{1'b0}};
      seg3_end_value <= {DATA_W{1'b0}};
      sclk_d_ff <= 1'b0;
      ft_d_ff <= 1'b0;
      lvl_d_ff <= 1'b0;
      pixel_open_ff <= 1'b0;
    end else if (clk_en) begin
      seg2_end_value <= join_end(seg2_end_high_in, seg2_end_low_bits_ff);
      seg3_end_value <= join_end(seg3_end_high_bits_ff[`CPBID_HIGH_W-1:0],
                                 seg3_end_low_bits_ff);
      sclk_d_ff <= sclk_s;
      ft_d_ff <= ft_s;
      lvl_d_ff <= lvl_s;
      if (ft_rise) begin
        pixel_open_ff <= 1'b1;
      end else if (lvl_rise) begin
        pixel_open_ff <= 1'b0;
      end
    end
  end

  cpbid_pixel_out #(
    .DATA_W(DATA_W)
  ) u_pixel_out (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .level_rise(lvl_rise),
    .level_clk_level(lvl_s),
    .strobe_select(ctrl_ff[`CPBID_CTRL_STROBE_SEL]),
    .adc_sample(adc_sample),
    .seg2_end(seg2_end_value),
    .seg3_end(seg3_end_value),
    .data_ff(pixel_data_out),
    .strobe_ff(pixel_strobe_out),
    .segment_ff(segment_code)
  );

endmodule // cpbid_top

// ==== testbench/cpbid_top_chk.sv ====
// Purpose: bus and output checks for cpbid_top
// Assumes: bound to cpbid_top, one clock domain
// Notes: live waits out the reset synchroniser
`timescale 1ns/1ps
module cpbid_chk #(
  parameter [7:0] PART_IDENTITY = 8'h5a,
  parameter [7:0] SILICON_REVISION = 8'h01
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // bus
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // segment values
  input wire logic [4:0] seg2_end_high_in,
  input wire logic [12:0] seg2_end_value
);
  logic [1:0] rcnt_ff;
  logic live;
  logic rd_done;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rcnt_ff <= 2'h0;
    else if (rcnt_ff != 2'h3) rcnt_ff <= rcnt_ff + 2'h1;
  end
  assign live = (rcnt_ff == 2'h3) && clk_en;
  assign rd_done = live && avs_read && !avs_waitrequest;
  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_answer_next: assert property (
    live && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_single: assert property (
    live && !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  chk_idle_wait: assert property (
    live && !(avs_read || avs_write) && $past(!(avs_read || avs_write)) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  chk_unaligned_zero: assert property (
    rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0000_0000)
    else $error("unaligned read not zero");
  chk_upper_zero: assert property (
    rd_done |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  chk_id_value: assert property (
    rd_done && avs_address == 9'h094 |-> avs_readdata[7:0] == PART_IDENTITY)
    else $error("identity read wrong");
  chk_rev_value: assert property (
    rd_done && avs_address == 9'h098 |-> avs_readdata[7:0] == SILICON_REVISION)
    else $error("revision read wrong");
  chk_rsvd_zero: assert property (
    rd_done && avs_address == 9'h08c |-> avs_readdata[7:5] == 3'h0)
    else $error("reserved bits read set");
  chk_high_join: assert property (
    live && $past(clk_en) |-> seg2_end_value[12:8] == $past(seg2_end_high_in))
    else $error("second segment high bits wrong");
  cover property (rd_done && avs_address == 9'h094);
  cover property (live && avs_write && !avs_waitrequest);
  cover property (rd_done && avs_address[1:0] != 2'h0);
endmodule // cpbid_chk

// ==== testbench/cpbid_far_model.sv ====
// Purpose: timing generator and serial host in front of cpbid_top
// Assumes: one request at a time, busy covers it
// Notes: every phase lasts four system clocks, except the eight-clock hold after the level clock falls
`timescale 1ns/1ps
module cpbid_far_model (
  // clock and requests
  input wire logic clk_sys,
  input wire logic px_go,
  input wire logic ser_go,
  input wire logic ser_bad,
  input wire logic [15:0] ser_frame,
  // pins
  input wire logic serial_data_out,
  output logic clamp_in,
  output logic feedthrough_sample_clk,
  output logic level_sample_clk,
  output logic [12:0] adc_sample,
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_data_in,
  output logic [7:0] ser_rdata,
  output logic busy
);
  initial begin
    {clamp_in, feedthrough_sample_clk, level_sample_clk, serial_clk} = 4'h0;
    {serial_select_n, serial_data_in, busy} = 3'h4;
    adc_sample = 13'h0000;
    ser_rdata = 8'h00;
  end
  always begin
    @(posedge clk_sys);
    if (px_go) begin
      busy <= 1'b1;
      adc_sample <= ser_frame[12:0];
      clamp_in <= 1'b1;
      feedthrough_sample_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      {feedthrough_sample_clk, clamp_in} <= 2'h0;
      repeat (4) @(posedge clk_sys);
      level_sample_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      level_sample_clk <= 1'b0;
      repeat (8) @(posedge clk_sys);
      adc_sample <= ~ser_frame[12:0];
      busy <= 1'b0;
    end else if (ser_go) begin
      busy <= 1'b1;
      serial_select_n <= ser_bad;
      for (int i = 15; i >= 0; i--) begin
        serial_data_in <= ser_frame[i];
        repeat (4) @(posedge clk_sys);
        // host takes read data at each rise of the data byte
        if (i < 8) ser_rdata <= {ser_rdata[6:0], serial_data_out};
        serial_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        serial_clk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      serial_select_n <= 1'b1;
      serial_data_in <= ~ser_frame[0];
      repeat (4) @(posedge clk_sys);
      busy <= 1'b0;
    end
  end
endmodule // cpbid_far_model

// ==== testbench/tb_top.sv ====
// Purpose: register, serial and pixel tests of cpbid_top
// Assumes: clk_en and byteenable held on
// Notes: bus tasks wait for waitrequest low
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ID_EXP = 8'h5a; // arbitrary value
  localparam logic [7:0] REV_EXP = 8'h01; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, serial_clk, serial_select_n, serial_data_in, serial_data_out;
  logic clamp_in, feedthrough_sample_clk, level_sample_clk, busy, pixel_strobe_out;
  logic px_go = 1'b0;
  logic ser_go = 1'b0;
  logic ser_bad = 1'b0;
  logic [15:0] ser_frame = 16'h0000;
  logic [7:0] ser_rdata;
  logic [4:0] seg2_end_high_in = 5'h00;
  logic [12:0] adc_sample, pixel_data_out, seg2_end_value, seg3_end_value;
  int n_fail = 0;
  int total_checks = 0;
  int n_strobe = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pixel_strobe_out === 1'b1) n_strobe++;
  cpbid_top #(.DATA_W(13), .PART_IDENTITY(ID_EXP), .SILICON_REVISION(REV_EXP)) cpbid_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .clamp_in(clamp_in), .feedthrough_sample_clk(feedthrough_sample_clk),
    .level_sample_clk(level_sample_clk), .adc_sample(adc_sample),
    .seg2_end_high_in(seg2_end_high_in), .pixel_data_out(pixel_data_out),
    .pixel_strobe_out(pixel_strobe_out), .seg2_end_value(seg2_end_value),
    .seg3_end_value(seg3_end_value));
  cpbid_far_model cpbid_far_model_inst (
    .clk_sys(clk_sys), .px_go(px_go), .ser_go(ser_go), .ser_bad(ser_bad),
    .ser_frame(ser_frame), .clamp_in(clamp_in), .feedthrough_sample_clk(feedthrough_sample_clk),
    .level_sample_clk(level_sample_clk), .adc_sample(adc_sample), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .ser_rdata(ser_rdata), .busy(busy));
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_fail++;
      final_report();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("read %h", a), {24'h00_0000, e}, q);
  endtask
  task automatic far(input logic px, input logic bad, input logic [15:0] fr);
    int i;
    px_go <= px;
    ser_go <= !px;
    ser_bad <= bad;
    ser_frame <= fr;
    repeat (2) @(posedge clk_sys);
    px_go <= 1'b0;
    ser_go <= 1'b0;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys);
    if (i == 400) begin
      n_fail++;
      final_report();
    end
    @(posedge clk_sys);
  endtask
  initial begin
    do_reset();
    seg2_end_high_in <= 5'h0a;
    rd(9'h088, 8'h18);
    rd(9'h08c, 8'h0b);
    rd(9'h090, 8'h58);
    rd(9'h094, ID_EXP);
    rd(9'h098, REV_EXP);
    chk("seg3 value", 32'h0000_0b58, {19'h0_0000, seg3_end_value});
    chk("seg2 value", 32'h0000_0a18, {19'h0_0000, seg2_end_value});
    bus(1'b1, 9'h08c, 8'hff);
    rd(9'h08c, 8'h1f);
    bus(1'b1, 9'h088, 8'ha5);
    rd(9'h088, 8'ha5);
    bus(1'b1, 9'h090, 8'hc3);
    rd(9'h090, 8'hc3);
    bus(1'b1, 9'h094, 8'h00);
    bus(1'b1, 9'h098, 8'hff);
    rd(9'h094, ID_EXP);
    rd(9'h098, REV_EXP);
    rd(9'h089, 8'h00);
    rd(9'h0fc, 8'h00);
    chk("seg3 value", 32'h0000_1fc3, {19'h0_0000, seg3_end_value});
    far(1'b0, 1'b0, 16'h243c);
    rd(9'h090, 8'h3c);
    far(1'b0, 1'b1, 16'h2411);
    rd(9'h090, 8'h3c);
    far(1'b0, 1'b0, 16'ha400);
    chk("serial read", 32'h0000_003c, {24'h00_0000, ser_rdata});
    bus(1'b1, 9'h0c0, 8'h01);
    rd(9'h0c0, 8'h01);
    n_strobe = 0;
    far(1'b1, 1'b0, 16'h1a5c);
    chk("pixel data", 32'h0000_1a5c, {19'h0_0000, pixel_data_out});
    chk("valid pulses", 32'h0000_0001, n_strobe);
    rd(9'h0c4, 8'h04);
    bus(1'b1, 9'h0c0, 8'h00);
    n_strobe = 0;
    far(1'b1, 1'b0, 16'h0001);
    chk("pixel data", 32'h0000_0001, {19'h0_0000, pixel_data_out});
    chk("clock copy", 32'h0000_0004, n_strobe);
    rd(9'h0c4, 8'h00);
    do_reset();
    chk("pixel after reset", 32'h0000_0000, {19'h0_0000, pixel_data_out});
    rd(9'h088, 8'h18);
    rd(9'h08c, 8'h0b);
    rd(9'h090, 8'h58);
    final_report();
  end
endmodule // tb_top
bind cpbid_top cpbid_chk #(.PART_IDENTITY(PART_IDENTITY), .SILICON_REVISION(SILICON_REVISION))
  cpbid_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .seg2_end_high_in(seg2_end_high_in), .seg2_end_value(seg2_end_value));
